//--- dct_pkg.sv
// Shared constants, register map and types for the counter/timer block.
`default_nettype none
package dct_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int BYTE_W = 8;
    localparam int CNT_W  = 16;
    localparam int SYN_W  = 6;
    localparam int DIV_W  = 4;

    // Word offsets of the register map, in byte addresses.
    localparam logic [ADDR_W-1:0] OFF_AUX   = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_UPPER = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_LOWER = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_ISR   = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_IMR   = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_START = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_STOP  = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_OPCFG = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h20;

    // Field positions.
    localparam int AUX_SRC_LSB   = 4;
    localparam int AUX_SRC_MSB   = 6;
    localparam int ISR_READY_BIT = 3;
    localparam int OPCFG_CT_BIT  = 0;
    localparam int OPCFG_LVL_BIT = 1;
    localparam int OPCFG_W       = 2;

    // Bit positions inside the synchronised source vector.
    localparam int SYN_IP2 = 0;
    localparam int SYN_EXT = 4;
    localparam int SYN_TXA = 4;
    localparam int SYN_TXB = 5;

    // Reset values and counting constants.
    localparam logic [BYTE_W-1:0]  BYTE_RST  = 8'h00;
    localparam logic [OPCFG_W-1:0] OPCFG_RST = 2'h2;
    localparam logic [CNT_W-1:0]   CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0]   CNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0]   CNT_ALL1  = 16'hFFFF;
    localparam logic [DIV_W-1:0]   DIV16_MAX = 4'hF;
    localparam logic [DIV_W-1:0]   DIV_ZERO  = 4'h0;

    // Source-select codes; the top bit selects timer mode.
    typedef enum logic [2:0] {
        CNT_IP2    = 3'b000,
        CNT_TXA    = 3'b001,
        CNT_TXB    = 3'b010,
        CNT_OSC16  = 3'b011,
        TMR_IP2    = 3'b100,
        TMR_IP2_16 = 3'b101,
        TMR_OSC    = 3'b110,
        TMR_OSC16  = 3'b111
    } dct_src_e;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0]   byteenable;
    } dct_avl_req_s;
endpackage
`default_nettype wire

//--- dct_counter_timer.sv
// Counter/timer with Avalon-MM register slave, source selection and output pin.
// Notes on behaviour
// [RULE1] The counter is sixteen bits wide and counts down from a software value.
// [RULE2] A three-bit source field picks mode and the counted source.
// [RULE3] In counter mode codes 001 and 010 count channel A or B transmit clocks.
// [RULE4] Top field bit set means timer mode; low bits pick input or oscillator.
// [RULE5] The timer output feeds both channels' clock-select multiplexers.
// [RULE6] Timer square wave period is twice the count in source periods.
// [RULE7] Count equals upper byte times 256 plus lower byte, unsigned.
// [RULE8] Output pin 3 carries the square wave when assigned to the timer.
// [RULE9] Used as bit clock, the timer output is a 16X clock.
// [RULE10] Timer count writes apply from the next half cycle only.
// [RULE11] Start loads the count and begins; timer mode then runs freely.
// [RULE12] Start while timing aborts the cycle and restarts with current registers.
// [RULE13] Timer mode sets the ready bit once per square-wave cycle.
// [RULE14] Ready raises the interrupt only when its mask bit is set.
// [RULE15] Stop in timer mode clears ready but keeps the wave running.
// [RULE16] Counter mode counts pulses down after start and flags zero.
// [RULE17] Counter mode wraps past zero to all ones until stopped.
// [RULE18] Counter mode pin 3 stays high until zero, low after; stop restores it.
// [RULE19] Start while counting restarts from the current count registers.
// [RULE20] Counter mode count writes take effect only at the next start.
// [RULE21] Input pins 2 to 5 are offered as direct external channel clocks.
// [RULE22] Selected source is synchronised and counted on its rising edges.
// [RULE23] Timer mode reloads and toggles the wave at each expiry.
// [RULE24] Software programs count and source before start, and stops to acknowledge.
`default_nettype none
module dct_counter_timer (
    input  wire logic                  ref_clk,        // 100 MHz oscillator clock
    input  wire logic                  rst_n,          // Asynchronous reset, active low
    input  wire dct_pkg::dct_avl_req_s avl_req,        // Avalon-MM request group
    output logic [dct_pkg::DATA_W-1:0] avl_readdata,   // Avalon-MM read data
    output logic                       avl_waitrequest,// Avalon-MM wait request
    input  wire logic [3:0]            general_inputs_2_to_5, // Input pins 2 to 5
    input  wire logic                  chan_a_tx_clock,// Channel A transmit 1X clock
    input  wire logic                  chan_b_tx_clock,// Channel B transmit 1X clock
    output logic                       general_output_3,  // Output pin 3
    output logic                       ct_clk_out,     // Timer clock to clock selects
    output logic                       ct_bit_tick,    // One pulse per 16 timer cycles
    output logic [3:0]                 ext_clk_out,    // Synchronised pins 2 to 5
    output logic                       irq             // Interrupt, active high
);
    localparam int CW = dct_pkg::CNT_W;
    localparam int BW = dct_pkg::BYTE_W;

    logic [dct_pkg::SYN_W-1:0]   sync1_q;
    logic [dct_pkg::SYN_W-1:0]   sync2_q;
    logic [dct_pkg::SYN_W-1:0]   sync3_q;
    logic [dct_pkg::SYN_W-1:0]   rise;
    logic [dct_pkg::DIV_W-1:0]   osc_div_q;
    logic [dct_pkg::DIV_W-1:0]   ip2_div_q;
    logic [dct_pkg::DIV_W-1:0]   bit_div_q;
    logic                        osc16_tick;
    logic                        ip216_tick;
    logic                        tick;
    logic                        wait_q;
    logic [dct_pkg::DATA_W-1:0]  rdata_q;
    logic [BW-1:0]               aux_q;
    logic [BW-1:0]               upper_q;
    logic [BW-1:0]               lower_q;
    logic [BW-1:0]               imr_q;
    logic [dct_pkg::OPCFG_W-1:0] opcfg_q;
    logic [CW-1:0]               count_q;
    logic [CW-1:0]               reload;
    logic                        running_q;
    logic                        sq_q;
    logic                        tc_q;
    logic                        ready_q;
    logic                        op3_q;
    logic                        ct_clk_q;
    logic                        bit_tick_q;
    logic                        irq_q;
    logic [3:0]                  ext_q;
    logic                        req_any;
    logic                        fire;
    logic                        wr_fire;
    logic                        start_fire;
    logic                        stop_fire;
    logic                        timer_mode;
    logic                        expire;
    logic                        ready_set;
    logic                        sq_rise_ev;
    logic [dct_pkg::DATA_W-1:0]  rmux;
    dct_pkg::dct_src_e           src;

    assign avl_readdata     = rdata_q;
    assign avl_waitrequest  = wait_q;
    assign general_output_3 = op3_q;
    assign ct_clk_out       = ct_clk_q;
    assign ct_bit_tick      = bit_tick_q;
    assign ext_clk_out      = ext_q;
    assign irq              = irq_q;

    // Source synchronisers; stage one feeds stage two only.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {chan_b_tx_clock, chan_a_tx_clock, general_inputs_2_to_5};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign rise = sync2_q & ~sync3_q; // RULE22

    // Pins 2 to 5 go out to the clock-select multiplexers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= '0;
        end else begin
            ext_q <= sync2_q[dct_pkg::SYN_EXT-1:0]; // RULE21
        end
    end

    // Divide-by-16 prescalers for the oscillator and for input pin 2.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_div_q <= dct_pkg::DIV_ZERO;
            ip2_div_q <= dct_pkg::DIV_ZERO;
        end else begin
            osc_div_q <= osc_div_q + 1'b1;
            if (rise[dct_pkg::SYN_IP2]) begin
                ip2_div_q <= ip2_div_q + 1'b1;
            end
        end
    end
    assign osc16_tick = (osc_div_q == dct_pkg::DIV16_MAX);
    assign ip216_tick = rise[dct_pkg::SYN_IP2] && (ip2_div_q == dct_pkg::DIV16_MAX);

    assign src        = dct_pkg::dct_src_e'(aux_q[dct_pkg::AUX_SRC_MSB:dct_pkg::AUX_SRC_LSB]);
    assign timer_mode = aux_q[dct_pkg::AUX_SRC_MSB]; // RULE4

    always_comb begin
        case (src) // RULE2
            dct_pkg::CNT_IP2:    tick = rise[dct_pkg::SYN_IP2];
            dct_pkg::CNT_TXA:    tick = rise[dct_pkg::SYN_TXA]; // RULE3
            dct_pkg::CNT_TXB:    tick = rise[dct_pkg::SYN_TXB]; // RULE3
            dct_pkg::CNT_OSC16:  tick = osc16_tick;
            dct_pkg::TMR_IP2:    tick = rise[dct_pkg::SYN_IP2];
            dct_pkg::TMR_IP2_16: tick = ip216_tick;
            dct_pkg::TMR_OSC:    tick = 1'b1;
            dct_pkg::TMR_OSC16:  tick = osc16_tick;
            default:             tick = 1'b0;
        endcase
    end

    // Bus slave: every access takes one wait state.
    assign req_any    = avl_req.read || avl_req.write;
    assign fire       = req_any && !wait_q;
    assign wr_fire    = fire && avl_req.write && avl_req.byteenable[0];
    assign start_fire = fire && (avl_req.address == dct_pkg::OFF_START);
    assign stop_fire  = fire && (avl_req.address == dct_pkg::OFF_STOP);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if (req_any && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_comb begin
        rmux = '0;
        case (avl_req.address)
            dct_pkg::OFF_AUX:   rmux[BW-1:0] = aux_q;
            dct_pkg::OFF_UPPER: rmux[BW-1:0] = upper_q;
            dct_pkg::OFF_LOWER: rmux[BW-1:0] = lower_q;
            dct_pkg::OFF_ISR:   rmux[dct_pkg::ISR_READY_BIT] = ready_q;
            dct_pkg::OFF_IMR:   rmux[BW-1:0] = imr_q;
            dct_pkg::OFF_OPCFG: rmux[dct_pkg::OPCFG_W-1:0] = opcfg_q;
            dct_pkg::OFF_COUNT: rmux[CW-1:0] = count_q;
            default:            rmux = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (avl_req.read && wait_q) begin
            rdata_q <= rmux;
        end
    end

    // Software registers; unmapped writes are dropped.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_q   <= dct_pkg::BYTE_RST;
            upper_q <= dct_pkg::BYTE_RST;
            lower_q <= dct_pkg::BYTE_RST;
            imr_q   <= dct_pkg::BYTE_RST;
            opcfg_q <= dct_pkg::OPCFG_RST;
        end else if (wr_fire) begin
            case (avl_req.address)
                dct_pkg::OFF_AUX:   aux_q   <= avl_req.writedata[BW-1:0];
                dct_pkg::OFF_UPPER: upper_q <= avl_req.writedata[BW-1:0];
                dct_pkg::OFF_LOWER: lower_q <= avl_req.writedata[BW-1:0];
                dct_pkg::OFF_IMR:   imr_q   <= avl_req.writedata[BW-1:0];
                dct_pkg::OFF_OPCFG: opcfg_q <= avl_req.writedata[dct_pkg::OPCFG_W-1:0];
                default:            aux_q   <= aux_q;
            endcase
        end
    end

    // Concatenation is upper times 256 plus lower, unsigned.
    assign reload = {upper_q, lower_q}; // RULE7

    assign expire     = running_q && tick && (count_q <= dct_pkg::CNT_ONE);
    assign sq_rise_ev = timer_mode && expire && !sq_q && !start_fire;

    // The count registers are sampled only at start, or at a timer half cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q   <= dct_pkg::CNT_ZERO;
            running_q <= 1'b0;
            sq_q      <= 1'b1;
            tc_q      <= 1'b0;
        end else if (start_fire) begin
            count_q   <= reload; // RULE1 RULE11 RULE12 RULE19 RULE20
            running_q <= 1'b1;
            sq_q      <= 1'b1;
            tc_q      <= 1'b0;
        end else if (timer_mode) begin
            tc_q <= 1'b0;
            if (expire) begin
                count_q <= reload; // RULE10 RULE23
                sq_q    <= !sq_q; // RULE6 RULE23
            end else if (running_q && tick) begin
                count_q <= count_q - 1'b1;
            end
        end else begin
            sq_q <= 1'b1;
            if (stop_fire) begin
                running_q <= 1'b0;
                tc_q      <= 1'b0; // RULE18
            end else if (running_q && tick) begin
                count_q <= count_q - 1'b1; // RULE16 RULE17
                if (count_q == dct_pkg::CNT_ONE) begin
                    tc_q <= 1'b1;
                end
            end
        end
    end

    // Ready: in timer mode a set in the same cycle as a clear wins; in counter mode the stop wins.
    always_comb begin
        if (timer_mode) begin
            ready_set = expire && sq_q && !start_fire; // RULE13
        end else begin
            ready_set = running_q && tick && (count_q == dct_pkg::CNT_ONE)
                        && !start_fire && !stop_fire; // RULE16
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_set || (ready_q && !stop_fire); // RULE15 RULE18
        end
    end

    // Pin, clock and interrupt outputs.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op3_q      <= 1'b1;
            ct_clk_q   <= 1'b1;
            bit_tick_q <= 1'b0;
            bit_div_q  <= dct_pkg::DIV_ZERO;
            irq_q      <= 1'b0;
        end else begin
            if (!opcfg_q[dct_pkg::OPCFG_CT_BIT]) begin
                op3_q <= opcfg_q[dct_pkg::OPCFG_LVL_BIT];
            end else if (timer_mode) begin
                op3_q <= sq_q; // RULE8
            end else begin
                op3_q <= !tc_q; // RULE18
            end
            ct_clk_q <= sq_q; // RULE5
            if (sq_rise_ev) begin
                bit_div_q <= bit_div_q + 1'b1;
            end
            bit_tick_q <= sq_rise_ev && (bit_div_q == dct_pkg::DIV16_MAX); // RULE9
            irq_q      <= ready_q && imr_q[dct_pkg::ISR_READY_BIT]; // RULE14
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_bus_one_wait: assert property (req_any && wait_q |=> !wait_q) // RULE24
        else $error("access not answered after one wait state");
    a_start_loads: assert property (start_fire |=> count_q == $past(reload) && running_q) // RULE11
        else $error("start did not load the count");
    a_timer_toggle: assert property (timer_mode && expire && !start_fire
                                     |=> sq_q != $past(sq_q) && count_q == $past(reload)) // RULE23
        else $error("timer expiry did not toggle and reload");
    a_timer_ready: assert property (timer_mode && expire && sq_q && !start_fire
                                    |=> ready_q) // RULE13
        else $error("ready not set on square-wave cycle");
    a_stop_keeps: assert property (timer_mode && stop_fire && running_q && !ready_set
                                   |=> running_q && !ready_q) // RULE15
        else $error("timer stop misbehaved");
    a_ctr_wrap: assert property (!timer_mode && running_q && tick && count_q == dct_pkg::CNT_ZERO
                                 && !start_fire && !stop_fire
                                 |=> count_q == dct_pkg::CNT_ALL1) // RULE17
        else $error("counter did not wrap");
    a_ctr_zero: assert property (!timer_mode && running_q && tick && count_q == dct_pkg::CNT_ONE
                                 && !start_fire && !stop_fire |=> ready_q && tc_q) // RULE16
        else $error("terminal count not flagged");
    a_ctr_stop: assert property (!timer_mode && stop_fire && !start_fire
                                 |=> !running_q && !ready_q ##1 op3_q
                                     || !opcfg_q[dct_pkg::OPCFG_CT_BIT]) // RULE18
        else $error("counter stop did not restore pin");
    a_irq_mask: assert property (!imr_q[dct_pkg::ISR_READY_BIT] && $stable(imr_q) |=> !irq_q) // RULE14
        else $error("masked ready raised interrupt");
    a_ctr_hold: assert property (!timer_mode && !start_fire && $stable(aux_q) && !tick
                                 |=> $stable(count_q)) // RULE20
        else $error("counter changed without a source pulse");

    c_timer_ready: cover property (timer_mode && ready_set);
    c_ctr_wrap:    cover property (!timer_mode && running_q && tick && count_q == dct_pkg::CNT_ZERO);
    c_restart:     cover property (start_fire && running_q);
    c_bit_tick:    cover property (bit_tick_q);
endmodule
`default_nettype wire

//--- dct_src_model.sv
// Behavioural far side: the counted input pins and both channel transmit clocks.
`default_nettype none
module dct_src_model (
    input  wire logic       ref_clk, // Bench clock
    output logic [3:0]      pins,    // Input pins 2 to 5
    output logic            txa,     // Channel A transmit 1X clock
    output logic            txb      // Channel B transmit 1X clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lvl;
    logic [2:0] hi;
    assign pins = {hi, lvl[0]};
    assign txa  = lvl[1];
    assign txb  = lvl[2];
    initial begin
        lvl = 3'h0;
        hi  = 3'h0;
    end
    // Clocks stand still between bursts; each pulse lasts three cycles high and low.
    task automatic pulse(input int s, input int k);
        repeat (k) begin
            @(posedge ref_clk);
            lvl <= 3'(1 << s);
            repeat (3) @(posedge ref_clk);
            lvl <= 3'h0;
            repeat (2) @(posedge ref_clk);
        end
    endtask
    task automatic set_hi(input logic [2:0] v);
        @(posedge ref_clk);
        hi <= v;
    endtask
endmodule
`default_nettype wire

//--- dct_counter_timer_bench.sv
// Self-checking bench for the counter/timer block against a register and timing model.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module dct_counter_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       ref_clk;
    logic                       rst_n;
    dct_pkg::dct_avl_req_s      avl_req;
    logic [dct_pkg::DATA_W-1:0] avl_readdata;
    logic                       avl_waitrequest;
    logic [3:0]                 pins;
    logic                       txa;
    logic                       txb;
    logic                       general_output_3;
    logic                       ct_clk_out;
    logic                       ct_bit_tick;
    logic [3:0]                 ext_clk_out;
    logic                       irq;
    logic [31:0]                rd;
    logic [2:0]                 hi;
    int                         errors;
    int                         check_count;
    int                         per;
    int                         n;
    int                         src;
    int                         mdl[int];
    int                         msk[int];
    int                         cnts[$];

    dct_counter_timer u_dct_counter_timer (
        .ref_clk(ref_clk), .rst_n(rst_n), .avl_req(avl_req), .avl_readdata(avl_readdata),
        .avl_waitrequest(avl_waitrequest), .general_inputs_2_to_5(pins),
        .chan_a_tx_clock(txa), .chan_b_tx_clock(txb), .general_output_3(general_output_3),
        .ct_clk_out(ct_clk_out), .ct_bit_tick(ct_bit_tick), .ext_clk_out(ext_clk_out),
        .irq(irq)
    );
    dct_src_model u_dct_src_model (.ref_clk(ref_clk), .pins(pins), .txa(txa), .txb(txb));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole sequence needs at most about a quarter of this span.
    initial begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    task automatic clk(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // Only the watchdog ends a wait that never completes.
    task automatic bus(input logic w, input logic [5:0] a, input int d, input logic [3:0] be,
                       output logic [31:0] r);
        @(posedge ref_clk);
        avl_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
        do begin
            @(posedge ref_clk);
        end while (avl_waitrequest !== 1'b0);
        r = avl_readdata;
        avl_req.read <= 1'b0;
        avl_req.write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input int v);
        bus(1'b1, a, v, 4'h1, rd);
        if (msk.exists(a)) mdl[a] = v & msk[a];
    endtask

    task automatic rdc(input logic [5:0] a);
        bus(1'b0, a, 0, 4'hF, rd);
        `CHK(rd, mdl[a])
    endtask

    task automatic interrupt_status_reg(input int v);
        mdl[12] = v;
        rdc(dct_pkg::OFF_ISR);
    endtask

    // Start loads the model count from upper and lower bytes; byte enables are ignored.
    task automatic go();
        bus(1'b1, dct_pkg::OFF_START, 0, 4'h0, rd);
        mdl[32] = mdl[4] * 256 + mdl[8];
    endtask

    task automatic halt();
        bus(1'b1, dct_pkg::OFF_STOP, 0, 4'h0, rd);
    endtask

    // Source field and both count bytes are written before any start.
    task automatic prog(input int code, input int cnt);
        wr(dct_pkg::OFF_AUX, code << 4);
        wr(dct_pkg::OFF_UPPER, cnt >> 8);
        wr(dct_pkg::OFF_LOWER, cnt & 255);
    endtask

    // Pulses one source; the model counts only when it is the selected one.
    task automatic step(input int s, input int k, input int rdy);
        u_dct_src_model.pulse(s, k);
        clk(4);
        if (s == src) begin
            mdl[32] = (mdl[32] - k) & 65535;
            rdc(dct_pkg::OFF_COUNT);
        end
        if (rdy >= 0) interrupt_status_reg(rdy);
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? ct_clk_out : (s == 1) ? general_output_3 : ct_bit_tick;
    endfunction

    // Cycles between two successive rising edges of the chosen output.
    task automatic measure(input int s, output int p);
        int   k;
        int   r;
        logic prv;
        k = 0;
        r = 0;
        p = 0;
        prv = pick(s);
        while (r < 2 && k < 20000) begin
            @(posedge ref_clk);
            k++;
            if (r == 1) p++;
            if (pick(s) === 1'b1 && prv === 1'b0) r++;
            prv = pick(s);
        end
    endtask

    task automatic wait_ct(input logic v);
        int k;
        for (k = 0; k < 5000 && ct_clk_out === v; k++) @(posedge ref_clk);
        for (k = 0; k < 5000 && ct_clk_out !== v; k++) @(posedge ref_clk);
    endtask

    initial begin
        errors = 0;
        check_count = 0;
        src = 9;
        rst_n = 1'b0;
        avl_req = '0;
        mdl = '{0:0, 4:0, 8:0, 12:0, 16:0, 28:2, 32:0, 36:0};
        msk = '{0:255, 4:255, 8:255, 16:8, 28:3};
        rd = $urandom(32'hcea2);
        clk(5);
        rst_n <= 1'b1;
        `CHK(general_output_3, 1'b1)
        `CHK(irq, 1'b0)
        foreach (mdl[a]) rdc(6'(a));
        foreach (mdl[a]) if (a != 16) wr(6'(a), 32'h0000_00A5);
        bus(1'b1, dct_pkg::OFF_AUX, 32'h0000_0070, 4'h0, rd);
        foreach (mdl[a]) rdc(6'(a));
        wr(dct_pkg::OFF_OPCFG, 1);
        src = 0;
        prog(0, 3);
        go();
        rdc(dct_pkg::OFF_COUNT);
        step(0, 2, 0);
        `CHK(general_output_3, 1'b1)
        wr(dct_pkg::OFF_LOWER, 7);
        step(0, 1, 8);
        `CHK(general_output_3, 1'b0)
        step(0, 1, 8);
        go();
        step(0, 1, -1);
        halt();
        interrupt_status_reg(0);
        `CHK(general_output_3, 1'b1)
        go();
        rdc(dct_pkg::OFF_COUNT);
        halt();
        for (int c = 1; c <= 2; c++) begin
            src = c;
            prog(c, 1);
            go();
            step(3 - c, 1, 0);
            step(c, 1, 8);
            halt();
        end
        src = 9;
        prog(3, 2);
        go();
        interrupt_status_reg(0);
        clk(48);
        interrupt_status_reg(8);
        halt();
        prog(4, 2);
        go();
        halt();
        step(0, 1, 0);
        step(0, 1, 8);
        prog(5, 1);
        go();
        halt();
        step(0, 16, 8);
        cnts = '{259, 1 + $urandom_range(39), 1 + $urandom_range(39)};
        foreach (cnts[i]) begin
            prog(6, cnts[i]);
            go();
            measure(0, per);
            `CHK(per, 2 * cnts[i])
            measure(1, per);
            `CHK(per, 2 * cnts[i])
            if (cnts[i] < 64) begin
                measure(2, per);
                `CHK(per, 32 * cnts[i])
            end
        end
        // The first period after start depends on the prescaler phase, so skip it.
        prog(7, 3);
        go();
        measure(0, per);
        measure(0, per);
        `CHK(per, 32 * 3)
        prog(6, 20);
        wr(dct_pkg::OFF_IMR, 8);
        go();
        wait_ct(1'b0);
        clk(2);
        interrupt_status_reg(8);
        `CHK(irq, 1'b1)
        halt();
        interrupt_status_reg(0);
        measure(0, per);
        `CHK(per, 40)
        interrupt_status_reg(8);
        wr(dct_pkg::OFF_IMR, 0);
        clk(2);
        `CHK(irq, 1'b0)
        wr(dct_pkg::OFF_LOWER, 9);
        measure(0, per);
        measure(0, per);
        `CHK(per, 18)
        wr(dct_pkg::OFF_LOWER, 30);
        measure(0, per);
        wait_ct(1'b1);
        clk(20);
        go();
        for (n = 0; n < 200 && ct_clk_out !== 1'b0; n++) @(posedge ref_clk);
        `CHK(n > 26 && n < 34, 1'b1)
        hi = 3'($urandom_range(7));
        u_dct_src_model.set_hi(hi);
        clk(5);
        `CHK(ext_clk_out[3:1], hi)
        summarize();
    end
endmodule
`default_nettype wire
